// >>> hdl/mcrb_consts.svh
`ifndef MCRB_CONSTS_SVH
`define MCRB_CONSTS_SVH

// Register indices; byte address is four times the index
`define MCRB_IDX_P1_DATA      8'h90
`define MCRB_IDX_P0_DRIVE     8'h91
`define MCRB_IDX_SEG_SEL      8'h92
`define MCRB_IDX_P2_DRIVE     8'h93
`define MCRB_IDX_MISC_CFG     8'h94
`define MCRB_IDX_IRQ_FLAGS    8'h95
`define MCRB_IDX_P1_WAKE      8'h96
`define MCRB_IDX_CMD          8'h97

// Reset values
`define MCRB_RST_P1_DATA      8'hFF
`define MCRB_RST_P0_DRIVE     8'h00
`define MCRB_RST_SEG_SEL      8'h7F
`define MCRB_RST_P2_DRIVE     8'h00
`define MCRB_RST_MISC_CFG     8'hC1
`define MCRB_RST_IRQ_FLAGS    4'h0
`define MCRB_RST_P1_WAKE      8'h00

// Field positions
`define MCRB_SEG_P2H_HI       6
`define MCRB_SEG_P2H_LO       5
`define MCRB_SEG_P2L_HI       4
`define MCRB_SEG_P2L_LO       3
`define MCRB_SEG_P0_HI        2
`define MCRB_SEG_P0_LO        0
`define MCRB_CFG_IDLE_GATE    5
`define MCRB_CFG_ONE_WIRE     3
`define MCRB_CFG_WDT_SEL      2
`define MCRB_CFG_RATE_HI      1
`define MCRB_CFG_RATE_LO      0
`define MCRB_FLG_TOUCH        3
`define MCRB_FLG_INT2         2
`define MCRB_FLG_P1CHG        1
`define MCRB_FLG_SLOWTMR      0

// Command codes
`define MCRB_CMD_SW_RESET     8'h56
`define MCRB_CMD_PERMIT       8'h65

// Timing counts
`define MCRB_WDT_LONG         17'h10000
`define MCRB_WDT_SHORT        17'h08000
`define MCRB_ST_RATE_01       23'h008000
`define MCRB_ST_RATE_10       23'h004000
`define MCRB_ST_RATE_11       23'h002000
`define MCRB_ST_FULL          23'h7FFFFF

`endif

// >>> hdl/mcrb_pkg.sv
package mcrb_pkg;

    typedef enum logic [1:0] {
        MCRB_IDLE   = 2'b01,
        MCRB_ANSWER = 2'b10
    } mcrb_phase_e;

    typedef struct packed {
        logic [7:0] p0_drive;
        logic [6:0] p0_seg;
        logic [6:0] p2_seg;
        logic [6:0] p2_drive;
    } mcrb_pin_cfg_s;

    typedef struct packed {
        logic       touch;
        logic       int2_pin;
        logic [7:0] p1_pins;
        logic       slow_tick;
    } mcrb_evt_s;

endpackage

// >>> hdl/mcrb_top.sv
`include "mcrb_consts.svh"

module mcrb_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire mcrb_pkg::mcrb_evt_s    events,
    input  wire logic [3:0]             irq_ack,
    input  wire logic                   cpu_idle,
    output mcrb_pkg::mcrb_pin_cfg_s     pin_cfg,
    output logic      [7:0]             p1_out,
    output logic      [7:0]             p1_wake_en,
    output logic      [3:0]             irq_flags,
    output logic                        periph_clk_stop,
    output logic                        serial_one_wire,
    output logic      [16:0]            wdt_period,
    output logic      [1:0]             slow_crystal_gain,
    output logic                        supply_noise_filter,
    output logic                        sw_reset_pulse,
    output logic                        flash_permit
);

    // APB phase and answer
    mcrb_pkg::mcrb_phase_e phase_q, phase_d;
    logic [31:0]           prdata_q, prdata_d;
    logic                  pready_q, pready_d;
    logic                  pslverr_q, pslverr_d;
    logic [2:0]            idx_q, idx_d;
    logic                  wr_fire;
    logic                  hit;
    logic [7:0]            widx;
    logic [7:0]            wbyte;

    // Registers
    logic [7:0]            p1_data_q, p1_data_d;
    logic [7:0]            p0_drv_q, p0_drv_d;
    logic [7:0]            seg_sel_q, seg_sel_d;
    logic [6:0]            p2_drv_q, p2_drv_d;
    logic [7:0]            cfg_q, cfg_d;
    logic [3:0]            flags_q, flags_d;
    logic [7:0]            wake_q, wake_d;
    logic                  permit_q, permit_d;
    logic                  software_reset_command_q, software_reset_command_d;

    // Event sources
    logic [22:0]           st_cnt_q, st_cnt_d;
    logic                  st_evt;
    logic [22:0]           st_mask;
    logic                  int2_prev_q;
    logic [7:0]            p1_prev_q;
    logic [7:0]            p1_change;
    logic [3:0]            flag_set;

    // Derived pin outputs
    mcrb_pkg::mcrb_pin_cfg_s pin_cfg_q, pin_cfg_d;
    logic                  clk_stop_q, clk_stop_d;
    logic [16:0]           wdt_q, wdt_d;
    logic [6:0]            p0_seg;
    logic [6:0]            p2_seg;

    assign widx  = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign hit   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   (widx >= `MCRB_IDX_P1_DATA) && (widx <= `MCRB_IDX_CMD);
    assign wr_fire = psel && penable && pwrite && pready_q && !pslverr_q &&
                     (phase_q == mcrb_pkg::MCRB_ANSWER);

    // Bus slave: decode in setup, answer in first access cycle
    always_comb begin
        phase_d   = phase_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        idx_d     = idx_q;
        unique case (phase_q)
            mcrb_pkg::MCRB_IDLE: begin
                if (psel && !penable) begin
                    phase_d   = mcrb_pkg::MCRB_ANSWER;
                    pready_d  = 1'b1;
                    pslverr_d = !hit;
                    idx_d     = widx[2:0];
                    prdata_d  = 32'h0000_0000;
                    if (hit && !pwrite) begin
                        unique case (widx[2:0])
                            3'h0:    prdata_d[7:0] = p1_data_q;
                            3'h1:    prdata_d[7:0] = p0_drv_q;
                            3'h2:    prdata_d[7:0] = seg_sel_q;
                            3'h3:    prdata_d[6:0] = p2_drv_q;
                            3'h4:    prdata_d[7:0] = cfg_q;
                            3'h5:    prdata_d[3:0] = flags_q;
                            3'h6:    prdata_d[7:0] = wake_q;
                            3'h7:    prdata_d[0]   = permit_q;
                            default: prdata_d      = 32'h0000_0000;
                        endcase
                    end
                end
            end
            mcrb_pkg::MCRB_ANSWER: begin
                phase_d = mcrb_pkg::MCRB_IDLE;
            end
            default: phase_d = mcrb_pkg::MCRB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q   <= mcrb_pkg::MCRB_IDLE;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            idx_q     <= 3'h0;
        end else begin
            phase_q   <= phase_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            idx_q     <= idx_d;
        end
    end

    // Software-visible registers
    always_comb begin
        p1_data_d = p1_data_q;
        p0_drv_d  = p0_drv_q;
        seg_sel_d = seg_sel_q;
        p2_drv_d  = p2_drv_q;
        cfg_d     = cfg_q;
        wake_d    = wake_q;
        permit_d  = permit_q;
        software_reset_command_d   = 1'b0;
        if (wr_fire) begin
            unique case (idx_q)
                3'h0: p1_data_d = wbyte;
                3'h1: p0_drv_d  = wbyte;
                3'h2: seg_sel_d = {1'b0, wbyte[6:0]};
                3'h3: p2_drv_d  = wbyte[6:0];
                3'h4: cfg_d     = wbyte;
                3'h5: ;
                3'h6: wake_d    = wbyte;
                3'h7: begin
                    software_reset_command_d  = (wbyte == `MCRB_CMD_SW_RESET);
                    permit_d = (wbyte == `MCRB_CMD_PERMIT);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_data_q <= `MCRB_RST_P1_DATA;
            p0_drv_q  <= `MCRB_RST_P0_DRIVE;
            seg_sel_q <= `MCRB_RST_SEG_SEL;
            p2_drv_q  <= 7'h00;
            cfg_q     <= `MCRB_RST_MISC_CFG;
            wake_q    <= `MCRB_RST_P1_WAKE;
            permit_q  <= 1'b0;
            software_reset_command_q   <= 1'b0;
        end else begin
            p1_data_q <= p1_data_d;
            p0_drv_q  <= p0_drv_d;
            seg_sel_q <= seg_sel_d;
            p2_drv_q  <= p2_drv_d;
            cfg_q     <= cfg_d;
            wake_q    <= wake_d;
            permit_q  <= permit_d;
            software_reset_command_q   <= software_reset_command_d;
        end
    end

    // Segment decode per pin
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_port_zero_segment_sel
            assign p0_seg[gi] = ({1'b0, seg_sel_q[`MCRB_SEG_P0_HI:`MCRB_SEG_P0_LO]}
                                 + 4'(gi)) >= 4'h7;
        end
        for (gi = 0; gi < 3; gi++) begin : g_p2seg
            assign p2_seg[4 + gi] = ({1'b0, seg_sel_q[`MCRB_SEG_P2H_HI:`MCRB_SEG_P2H_LO]}
                                     + 3'(gi)) >= 3'h3;
            assign p2_seg[1 + gi] = ({1'b0, seg_sel_q[`MCRB_SEG_P2L_HI:`MCRB_SEG_P2L_LO]}
                                     + 3'(gi)) >= 3'h3;
        end
        for (gi = 0; gi < 8; gi++) begin : g_p1chg
            assign p1_change[gi] = wake_q[gi] &&
                                   (p1_prev_q[gi] != events.p1_pins[gi]);
        end
    endgenerate
    assign p2_seg[0] = 1'b0;

    // Pin and option outputs
    always_comb begin
        pin_cfg_d.p0_seg   = p0_seg;
        pin_cfg_d.p2_seg   = p2_seg;
        // Segment pins are not I/O, so drive is withheld there
        pin_cfg_d.p0_drive = p0_drv_q & ~{1'b0, p0_seg};
        pin_cfg_d.p2_drive = p2_drv_q & ~p2_seg;
        clk_stop_d = cfg_q[`MCRB_CFG_IDLE_GATE] && cpu_idle;
        wdt_d      = cfg_q[`MCRB_CFG_WDT_SEL] ? `MCRB_WDT_SHORT
                                               : `MCRB_WDT_LONG;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_cfg_q  <= '0;
            clk_stop_q <= 1'b0;
            wdt_q      <= `MCRB_WDT_LONG;
        end else begin
            pin_cfg_q  <= pin_cfg_d;
            clk_stop_q <= clk_stop_d;
            wdt_q      <= wdt_d;
        end
    end

    // Slow timer, advanced by the slow-clock enable
    always_comb begin
        unique case (cfg_q[`MCRB_CFG_RATE_HI:`MCRB_CFG_RATE_LO])
            2'h0: st_mask = `MCRB_ST_FULL;
            2'h1: st_mask = `MCRB_ST_RATE_01 - 23'h1;
            2'h2: st_mask = `MCRB_ST_RATE_10 - 23'h1;
            2'h3: st_mask = `MCRB_ST_RATE_11 - 23'h1;
            default: st_mask = `MCRB_ST_FULL;
        endcase
        st_evt   = events.slow_tick && ((st_cnt_q & st_mask) == st_mask);
        st_cnt_d = events.slow_tick ? st_cnt_q + 23'h1 : st_cnt_q;
    end

    // Interrupt flags: write clears zeros, service clears, set wins
    always_comb begin
        flag_set[`MCRB_FLG_TOUCH]   = events.touch;
        flag_set[`MCRB_FLG_INT2]    = int2_prev_q && !events.int2_pin;
        flag_set[`MCRB_FLG_P1CHG]   = |p1_change;
        flag_set[`MCRB_FLG_SLOWTMR] = st_evt;
        flags_d = flags_q;
        if (wr_fire && idx_q == 3'h5) begin
            flags_d = flags_d & wbyte[3:0];
        end
        flags_d = (flags_d & ~irq_ack) | flag_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q     <= `MCRB_RST_IRQ_FLAGS;
            st_cnt_q    <= 23'h0;
            int2_prev_q <= 1'b1;
            p1_prev_q   <= 8'hFF;
        end else begin
            flags_q     <= flags_d;
            st_cnt_q    <= st_cnt_d;
            int2_prev_q <= events.int2_pin;
            p1_prev_q   <= events.p1_pins;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign pin_cfg             = pin_cfg_q;
    assign p1_out              = p1_data_q;
    assign p1_wake_en          = wake_q;
    assign irq_flags           = flags_q;
    assign periph_clk_stop     = clk_stop_q;
    assign serial_one_wire     = cfg_q[`MCRB_CFG_ONE_WIRE];
    assign wdt_period          = wdt_q;
    assign slow_crystal_gain   = cfg_q[7:6];
    assign supply_noise_filter = cfg_q[4];
    assign sw_reset_pulse      = software_reset_command_q;
    assign flash_permit        = permit_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_p0_drive_pin: assert property (
        wr_fire && idx_q == 3'h1 |=> ##1 pin_cfg.p0_drive ==
            ($past(wbyte, 2) & ~{1'b0, pin_cfg.p0_seg}))
        else $error("port-0 drive does not follow write");

    a_p0_seg_all: assert property (
        presetn && seg_sel_q[2:0] == 3'h7 |=> pin_cfg.p0_seg == 7'h7F)
        else $error("port-0 segment decode wrong for full setting");

    a_p2_seg_upper: assert property (
        seg_sel_q[6:5] == 2'h1 |=> pin_cfg.p2_seg[6:4] == 3'h4)
        else $error("port-2 upper segment decode wrong");

    a_p2_seg_lower: assert property (
        seg_sel_q[4:3] == 2'h2 |=> pin_cfg.p2_seg[3:1] == 3'h6)
        else $error("port-2 lower segment decode wrong");

    a_idle_clk_gate: assert property (
        cfg_q[5] && cpu_idle |=> periph_clk_stop)
        else $error("peripheral clocks not stopped in idle");

    a_wdt_period: assert property (
        $past(cfg_q[2]) |-> wdt_period == 17'h08000)
        else $error("watchdog short period not selected");

    a_int2_edge: assert property (
        presetn && int2_prev_q && !events.int2_pin |=> irq_flags[2])
        else $error("int2 falling edge lost");

    a_flag_write: assert property (
        wr_fire && idx_q == 3'h5 && wbyte[3:0] == 4'hE && flag_set == 4'h0 && irq_ack == 4'h0
            |=> !irq_flags[0] && (irq_flags[3:1] == $past(flags_q[3:1])))
        else $error("flag write clear disturbed other flags");

    a_software_reset_command_pulse: assert property (
        wr_fire && idx_q == 3'h7 && wbyte == 8'h56
            |=> sw_reset_pulse ##1 !sw_reset_pulse)
        else $error("software reset not a one-cycle pulse");

    a_permit_cmd: assert property (
        wr_fire && idx_q == 3'h7 |=> flash_permit == ($past(wbyte) == 8'h65))
        else $error("flash permit does not follow command");

    a_apb_answer: assert property (
        psel && !penable && phase_q == mcrb_pkg::MCRB_IDLE
            |=> pready ##1 !pready)
        else $error("bus answer not in first access cycle");

    a_p2_drive_pin: assert property (
        wr_fire && idx_q == 3'h3 |=> ##1 pin_cfg.p2_drive ==
            ($past(wbyte[6:0], 2) & ~pin_cfg.p2_seg))
        else $error("port-2 drive does not follow write");

    a_wake_write: assert property (
        wr_fire && idx_q == 3'h6 |=> p1_wake_en == $past(wbyte))
        else $error("wake enables do not follow write");

    a_touch_set: assert property (
        presetn && events.touch |=> irq_flags[3])
        else $error("touch flag not set");

    a_p1chg_set: assert property (
        presetn && |p1_change |=> irq_flags[1])
        else $error("port-1 change flag not set");

    a_slow_set: assert property (
        presetn && st_evt |=> irq_flags[0])
        else $error("slow timer flag not set");

    a_cmd_read: assert property (
        psel && !penable && !pwrite && phase_q == mcrb_pkg::MCRB_IDLE && paddr == 12'h25C
            |=> prdata == {31'h0, flash_permit})
        else $error("command read does not show permit");

endmodule // mcrb_top

// >>> verification/mcrb_cpu_model.sv
module mcrb_cpu_model (
    input  wire logic        pclk,
    output logic      [11:0] paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        paddr   = 12'h000;
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        pwdata  = 32'h0;
    end

    // Request stands until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // Released lines stop showing the last value
        paddr   <= ~a;
        pwdata  <= ~{24'h0, d};
    endtask

    // Drops the permit once self-programming is over
    task automatic permit_done();
        logic [31:0] r;
        logic        e;
        xfer(1'h1, 12'h25C, 8'h00, r, e);
    endtask
endmodule // mcrb_cpu_model

// >>> verification/misc_control_register_bank_tb.sv
module misc_control_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    pclk;
    logic                    presetn;
    logic [11:0]             paddr;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    mcrb_pkg::mcrb_evt_s     events;
    logic [3:0]              irq_ack;
    logic                    cpu_idle;
    mcrb_pkg::mcrb_pin_cfg_s pin_cfg;
    logic [7:0]              p1_out;
    logic [7:0]              p1_wake_en;
    logic [3:0]              irq_flags;
    logic                    periph_clk_stop;
    logic                    serial_one_wire;
    logic [16:0]             wdt_period;
    logic [1:0]              slow_crystal_gain;
    logic                    supply_noise_filter;
    logic                    sw_reset_pulse;
    logic                    flash_permit;
    int                      err_count;
    int                      n_compared;
    int                      cycles;

    mcrb_top DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .irq_ack(irq_ack),
        .cpu_idle(cpu_idle), .pin_cfg(pin_cfg), .p1_out(p1_out),
        .p1_wake_en(p1_wake_en), .irq_flags(irq_flags),
        .periph_clk_stop(periph_clk_stop), .serial_one_wire(serial_one_wire),
        .wdt_period(wdt_period), .slow_crystal_gain(slow_crystal_gain),
        .supply_noise_filter(supply_noise_filter),
        .sw_reset_pulse(sw_reset_pulse), .flash_permit(flash_permit)
    );

    mcrb_cpu_model cpu (
        .pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    task automatic summarize();
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 50000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        cpu.xfer(1'h1, {2'h0, idx, 2'h0}, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        cpu.xfer(1'h0, {2'h0, idx, 2'h0}, 8'h00, r, e);
        chk(nm, {24'h0, exp}, r);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset();
        rd_chk("p1 data", 8'h90, 8'hFF);
        rd_chk("p0 drive", 8'h91, 8'h00);
        rd_chk("seg sel", 8'h92, 8'h7F);
        rd_chk("p2 drive", 8'h93, 8'h00);
        rd_chk("cfg", 8'h94, 8'hC1);
        chk("gain", 32'h3, slow_crystal_gain);
        chk("p1 out", 32'hFF, p1_out);
        rd_chk("flags", 8'h95, 8'h00);
        rd_chk("wake", 8'h96, 8'h00);
        rd_chk("cmd", 8'h97, 8'h00);
        chk("p0 seg", 32'h7F, pin_cfg.p0_seg);
        chk("p2 seg", 32'h7E, pin_cfg.p2_seg);
    endtask

    task automatic t_segs();
        for (int n = 0; n < 8; n++) begin
            wr(8'h92, n[7:0]);
            step(2);
            chk("p0 seg", (32'h7F << (7 - n)) & 32'h7F, pin_cfg.p0_seg);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h92, {1'h0, k[1:0], k[1:0], 3'h0});
            step(2);
            chk("p2 seg hi", (32'h70 << (3 - k)) & 32'h70, pin_cfg.p2_seg & 7'h70);
            chk("p2 seg lo", (32'h0E << (3 - k)) & 32'h0E, pin_cfg.p2_seg & 7'h0E);
        end
        wr(8'h92, 8'h00);
        wr(8'h91, 8'hFF);
        wr(8'h93, 8'hFF);
        step(2);
        chk("p0 drive", 32'hFF, pin_cfg.p0_drive);
        chk("p2 drive", 32'h7F, pin_cfg.p2_drive);
        wr(8'h92, 8'h07);
        step(2);
        chk("p0 drive seg", 32'h80, pin_cfg.p0_drive);
    endtask

    task automatic t_cfg();
        wr(8'h90, 8'h5A);
        #1;
        chk("p1 out", 32'h5A, p1_out);
        rd_chk("p1 rd", 8'h90, 8'h5A);
        wr(8'h94, 8'h3C);
        @(posedge pclk);
        cpu_idle <= 1'h1;
        step(2);
        chk("filter", 32'h1, supply_noise_filter);
        chk("gain low", 32'h0, slow_crystal_gain);
        chk("one wire", 32'h1, serial_one_wire);
        chk("wdt", 32'h08000, wdt_period);
        chk("clk stop", 32'h1, periph_clk_stop);
        @(posedge pclk);
        cpu_idle <= 1'h0;
        step(2);
        chk("clk run", 32'h0, periph_clk_stop);
        wr(8'h94, 8'h01);
        step(2);
        chk("wdt long", 32'h10000, wdt_period);
        chk("two wire", 32'h0, serial_one_wire);
    endtask

    task automatic t_flags();
        wr(8'h96, 8'h02);
        step(1);
        chk("wake", 32'h02, p1_wake_en);
        @(posedge pclk);
        events.p1_pins[0] <= 1'h0;
        step(2);
        chk("no wake flag", 32'h0, irq_flags);
        @(posedge pclk);
        events.touch <= 1'h1;
        events.int2_pin <= 1'h0;
        events.p1_pins[1] <= 1'h0;
        @(posedge pclk);
        events.touch <= 1'h0;
        step(2);
        chk("flags set", 32'hE, irq_flags);
        wr(8'h95, 8'hF7);
        #1;
        chk("touch clr", 32'h6, irq_flags);
        wr(8'h95, 8'hFF);
        #1;
        chk("keep ones", 32'h6, irq_flags);
        @(posedge pclk);
        irq_ack <= 4'h4;
        @(posedge pclk);
        irq_ack <= 4'h0;
        #1;
        chk("int2 ack", 32'h2, irq_flags);
        rd_chk("flags rd", 8'h95, 8'h02);
        wr(8'h95, 8'hFD);
        #1;
        chk("p1 clr", 32'h0, irq_flags);
    endtask

    task automatic ticks(input int n);
        @(posedge pclk);
        events.slow_tick <= 1'h1;
        repeat (n) @(posedge pclk);
        events.slow_tick <= 1'h0;
        step(2);
    endtask

    task automatic t_slow();
        wr(8'h94, 8'h03);
        ticks(8191);
        chk("slow early", 32'h0, irq_flags[0]);
        ticks(1);
        chk("slow flag", 32'h1, irq_flags[0]);
        wr(8'h95, 8'hFE);
        #1;
        chk("slow clr", 32'h0, irq_flags);
        // Free-running counter: align to the 16384 boundary first
        wr(8'h94, 8'h02);
        ticks(8192);
        wr(8'h95, 8'hFE);
        ticks(16383);
        chk("slow 10 early", 32'h0, irq_flags[0]);
        ticks(1);
        chk("slow 10 flag", 32'h1, irq_flags[0]);
        @(posedge pclk);
        irq_ack <= 4'h1;
        @(posedge pclk);
        irq_ack <= 4'h0;
        #1;
        chk("slow ack", 32'h0, irq_flags);
    endtask

    task automatic t_cmd();
        wr(8'h97, 8'h65);
        #1;
        chk("permit", 32'h1, flash_permit);
        rd_chk("cmd rd", 8'h97, 8'h01);
        wr(8'h97, 8'h56);
        #1;
        chk("sw reset", 32'h1, sw_reset_pulse);
        chk("permit off", 32'h0, flash_permit);
        step(1);
        chk("sw reset end", 32'h0, sw_reset_pulse);
        wr(8'h97, 8'h65);
        cpu.permit_done();
        #1;
        chk("permit done", 32'h0, flash_permit);
    endtask

    task automatic t_unmapped();
        logic [31:0] r;
        logic        e;
        cpu.xfer(1'h1, 12'h260, 8'hAA, r, e);
        chk("unmapped err", 32'h1, e);
        cpu.xfer(1'h1, 12'h251, 8'h00, r, e);
        chk("misaligned err", 32'h1, e);
        cpu.xfer(1'h1, 12'hE50, 8'h00, r, e);
        chk("alias err", 32'h1, e);
        cpu.xfer(1'h0, 12'h260, 8'h00, r, e);
        chk("unmapped rd", 32'h0, r);
        rd_chk("cfg kept", 8'h94, 8'h02);
    endtask

    task automatic t_rerun();
        @(posedge pclk);
        events  <= {1'h0, 1'h1, 8'hFF, 1'h0};
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
    endtask

    initial begin
        err_count  = 0;
        n_compared = 0;
        cycles     = 0;
        presetn    = 1'h0;
        events     = {1'h0, 1'h1, 8'hFF, 1'h0};
        irq_ack    = 4'h0;
        cpu_idle   = 1'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_segs();
        t_cfg();
        t_flags();
        t_slow();
        t_cmd();
        t_unmapped();
        t_rerun();
        summarize();
    end
endmodule // misc_control_register_bank_tb
